// >>> logic/wdt_core.sv
// Watchdog timer core with register port and interrupt
`timescale 1ns/1ps
module wdt_core
	import wdt_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Register port
	input wire logic [WDT_ADDR_W-1:0] reg_addr,
	input wire logic [WDT_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [WDT_DATA_W-1:0] reg_rdata,
	// Oscillators
	input wire logic low_freq_internal_osc,
	input wire logic lf_is_system_clock,
	input wire logic crystal_osc_mode,
	input wire logic osc_startup_timer_active,
	input wire logic osc_fail_detect,
	// Core events and configuration
	input wire logic config_watchdog_enable,
	input wire logic watchdog_clear_instr,
	input wire logic sleep_active,
	input wire logic wake_event,
	// Shared counter timer
	input wire logic shared_counter_tick,
	output logic shared_counter_presc_tick,
	// Results
	output logic watchdog_reset_req,
	output logic watchdog_wake,
	output logic watchdog_running,
	output logic irq
);

	typedef struct packed {
		logic [2:0] sync;
		logic lf_lvl;
		logic lf_seen;
		logic soft_watchdog_enable;
		logic [WDT_CTRL_PS_W-1:0] wdt_ps;
		logic prescaler_assign;
		logic [WDT_OPT_PS_W-1:0] prescale_rate_select;
		logic [WDT_ST_W-1:0] status;
		logic [WDT_ST_W-1:0] mask;
		logic [WDT_DATA_W-1:0] rdata;
		logic wake_hold;
		logic ost_q;
		wdt_state_t state;
		logic rst_req;
		logic wake;
		logic presc_tick;
	} wdt_core_st_t;

	wdt_core_st_t q;
	wdt_core_st_t d;

	logic lf_tick;
	logic enabled;
	logic hold;
	logic timeout;
	logic wdt_clr;
	logic ost_end;
	logic p16_out;
	logic p8_in;
	logic p8_clr;
	logic p8_out;
	logic final_tick;
	logic low_freq_stable_flag;
	logic [WDT_ST_W-1:0] events;
	logic [WDT_ST_W-1:0] w1c;

	// Synchroniser stages two and three agree
	function automatic logic sync_settled(input logic [2:0] s);
		return s[1] == s[2];
	endfunction

	// Counting state of the run machine
	function automatic logic is_running(input wdt_state_t s);
		return s == WDT_RUN;
	endfunction

	// Ratio field of a control word
	function automatic logic [WDT_CTRL_PS_W-1:0] ctrl_ratio(input logic [WDT_DATA_W-1:0] w);
		return w[WDT_CTRL_PS_LSB +: WDT_CTRL_PS_W];
	endfunction

	// Rate field of a shared counter word
	function automatic logic [WDT_OPT_PS_W-1:0] opt_rate(input logic [WDT_DATA_W-1:0] w);
		return w[WDT_OPT_PS_LSB +: WDT_OPT_PS_W];
	endfunction

	// Read mux of the register map
	function automatic logic [WDT_DATA_W-1:0] read_word(input wdt_core_st_t s, input logic [WDT_ADDR_W-1:0] a,
		input logic stable);
		logic [WDT_DATA_W-1:0] r;
		r = '0;
		case (a)
			WDT_ADR_CTRL: begin
				r[WDT_CTRL_SWEN_BIT] = s.soft_watchdog_enable;
				r[WDT_CTRL_PS_LSB +: WDT_CTRL_PS_W] = s.wdt_ps;
			end
			WDT_ADR_OPT: begin
				r[WDT_OPT_PSA_BIT] = s.prescaler_assign;
				r[WDT_OPT_PS_LSB +: WDT_OPT_PS_W] = s.prescale_rate_select;
			end
			WDT_ADR_STATUS: begin
				r[WDT_ST_W-1:0] = s.status;
			end
			WDT_ADR_MASK: begin
				r[WDT_ST_W-1:0] = s.mask;
			end
			WDT_ADR_OSC: begin
				r[WDT_OSC_STABLE_BIT] = stable;
				r[WDT_OSC_RUN_BIT] = is_running(s.state);
			end
			default: begin
				r = '0;
			end
		endcase
		return r;
	endfunction

	assign lf_tick = sync_settled(q.sync) && q.sync[2] && !q.lf_lvl;

	assign enabled = config_watchdog_enable || q.soft_watchdog_enable;

	// crystal wake holds until timer end
	assign hold = osc_startup_timer_active || q.wake_hold || (wake_event && crystal_osc_mode);

	assign ost_end = q.ost_q && !osc_startup_timer_active;

	assign final_tick = q.prescaler_assign ? p8_out : p16_out;
	assign timeout = is_running(q.state) && final_tick;

	// clear sources for counter and prescaler
	assign wdt_clr = watchdog_clear_instr || osc_fail_detect || !is_running(q.state) || timeout;

	// shared stage fed by its current user
	assign p8_in = q.prescaler_assign ? p16_out : shared_counter_tick;
	assign p8_clr = q.prescaler_assign && wdt_clr;

	// flag ignores watchdog use of the oscillator
	assign low_freq_stable_flag = lf_is_system_clock && q.lf_seen;

	assign events = {ost_end, timeout};
	assign w1c = (reg_wr && reg_addr == WDT_ADR_STATUS) ? reg_wdata[WDT_ST_W-1:0] : '0;

	wdt_presc #(
		.WIDTH(WDT_PRE16_W),
		.SEL_W(WDT_CTRL_PS_W),
		.BASE(WDT_PRE16_BASE)
	) u_pre16 (
		.clock(clock),
		.sys_rst(sys_rst),
		.clear(wdt_clr),
		.tick_in(lf_tick),
		.sel(q.wdt_ps),
		.tick_out(p16_out)
	);

	wdt_presc #(
		.WIDTH(WDT_PRE8_W),
		.SEL_W(WDT_OPT_PS_W),
		.BASE(WDT_PRE8_BASE)
	) u_pre8 (
		.clock(clock),
		.sys_rst(sys_rst),
		.clear(p8_clr),
		.tick_in(p8_in),
		.sel(q.prescale_rate_select),
		.tick_out(p8_out)
	);

	always_comb begin
		d = q;

		// Oscillator pin synchroniser
		d.sync = {q.sync[1:0], low_freq_internal_osc};
		if (sync_settled(q.sync) && (q.sync[2] != q.lf_lvl)) begin
			d.lf_lvl = q.sync[2];
		end
		if (lf_tick) begin
			d.lf_seen = 1'b1;
		end

		// Register writes
		if (reg_wr) begin
			case (reg_addr)
				WDT_ADR_CTRL: begin
					d.soft_watchdog_enable = reg_wdata[WDT_CTRL_SWEN_BIT];
					d.wdt_ps = ctrl_ratio(reg_wdata);
				end
				WDT_ADR_OPT: begin
					d.prescaler_assign = reg_wdata[WDT_OPT_PSA_BIT];
					d.prescale_rate_select = opt_rate(reg_wdata);
				end
				WDT_ADR_MASK: begin
					d.mask = reg_wdata[WDT_ST_W-1:0];
				end
				default: begin
				end
			endcase
		end

		// Sticky status, set beats clear
		d.status = (q.status & ~w1c) | events;

		// Read data for one cycle
		d.rdata = reg_rd ? read_word(q, reg_addr, low_freq_stable_flag) : '0;

		d.ost_q = osc_startup_timer_active;
		if (wake_event && crystal_osc_mode) begin
			d.wake_hold = 1'b1;
		end else if (ost_end || !crystal_osc_mode) begin
			d.wake_hold = 1'b0;
		end

		// Run state
		case (q.state)
			WDT_OFF: begin
				if (enabled) begin
					d.state = hold ? WDT_HOLD : WDT_RUN;
				end
			end
			WDT_HOLD: begin
				if (!hold) begin
					d.state = enabled ? WDT_RUN : WDT_OFF;
				end
			end
			WDT_RUN: begin
				if (!enabled) begin
					d.state = WDT_OFF;
				end else if (hold) begin
					d.state = WDT_HOLD;
				end
			end
			default: begin
				d.state = WDT_OFF;
			end
		endcase

		d.rst_req = timeout && !sleep_active;
		d.wake = timeout && sleep_active;

		d.presc_tick = q.prescaler_assign ? shared_counter_tick : p8_out;

		if (sys_rst) begin
			d.sync = '0;
			d.lf_lvl = 1'b0;
			d.lf_seen = 1'b0;
			d.soft_watchdog_enable = WDT_CTRL_RESET[WDT_CTRL_SWEN_BIT];
			d.wdt_ps = ctrl_ratio(WDT_CTRL_RESET);
			d.prescaler_assign = WDT_OPT_RESET[WDT_OPT_PSA_BIT];
			d.prescale_rate_select = opt_rate(WDT_OPT_RESET);
			d.status = WDT_ST_RESET;
			d.mask = WDT_ST_RESET;
			d.rdata = '0;
			d.wake_hold = 1'b0;
			d.ost_q = 1'b0;
			d.state = WDT_OFF;
			d.rst_req = 1'b0;
			d.wake = 1'b0;
			d.presc_tick = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		q <= d;
	end

	assign reg_rdata = q.rdata;
	assign shared_counter_presc_tick = q.presc_tick;
	assign watchdog_reset_req = q.rst_req;
	assign watchdog_wake = q.wake;
	assign watchdog_running = is_running(q.state);
	assign irq = |(q.status & q.mask);

endmodule

// >>> pkg/wdt_pkg.sv
// Constants and types shared by the watchdog timer core
package wdt_pkg;

	// Register port geometry
	localparam int WDT_ADDR_W = 4;
	localparam int WDT_DATA_W = 8;

	// Register offsets
	localparam logic [3:0] WDT_ADR_CTRL = 4'h0;
	localparam logic [3:0] WDT_ADR_OPT = 4'h1;
	localparam logic [3:0] WDT_ADR_STATUS = 4'h2;
	localparam logic [3:0] WDT_ADR_MASK = 4'h3;
	localparam logic [3:0] WDT_ADR_OSC = 4'h4;

	// Watchdog control register fields
	localparam int WDT_CTRL_SWEN_BIT = 0;
	localparam int WDT_CTRL_PS_LSB = 1;
	localparam int WDT_CTRL_PS_W = 4;
	localparam logic [7:0] WDT_CTRL_RESET = 8'h08;

	// Shared counter configuration fields
	localparam int WDT_OPT_PS_LSB = 0;
	localparam int WDT_OPT_PS_W = 3;
	localparam int WDT_OPT_PSA_BIT = 3;
	localparam logic [7:0] WDT_OPT_RESET = 8'h0F;

	// Status, mask and oscillator status bits
	localparam int WDT_ST_W = 2;
	localparam int WDT_ST_TIMEOUT = 0;
	localparam int WDT_ST_OSTEND = 1;
	localparam int WDT_OSC_STABLE_BIT = 0;
	localparam int WDT_OSC_RUN_BIT = 1;
	localparam logic [1:0] WDT_ST_RESET = 2'h0;

	// Prescaler geometry
	localparam int WDT_PRE16_W = 16;
	localparam int WDT_PRE16_BASE = 5;
	localparam int WDT_PRE8_W = 8;
	localparam int WDT_PRE8_BASE = 0;

	// Time base
	localparam int WDT_LFOSC_KHZ = 31;
	localparam int WDT_CLK_MHZ = 250;

	// Watchdog run state
	typedef enum logic [2:0] {
		WDT_OFF = 3'b001,
		WDT_HOLD = 3'b010,
		WDT_RUN = 3'b100
	} wdt_state_t;

endpackage

// >>> logic/wdt_presc.sv
// Power-of-two prescaler with selectable tap
`timescale 1ns/1ps
module wdt_presc
	import wdt_pkg::*;
#(
	parameter int WIDTH = 16,
	parameter int SEL_W = 4,
	parameter int BASE = 5
) (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Count control
	input wire logic clear,
	input wire logic tick_in,
	input wire logic [SEL_W-1:0] sel,
	// Divided tick
	output logic tick_out
);

	typedef struct packed {
		logic [WIDTH-1:0] cnt;
	} wdt_presc_st_t;

	wdt_presc_st_t q;
	wdt_presc_st_t d;
	logic [WIDTH-1:0] mask;

	// Low bits that must all be set for a carry out
	function automatic logic [WIDTH-1:0] tap_mask(input int shift);
		logic [WIDTH-1:0] m;
		m = '0;
		for (int i = 0; i < WIDTH; i++) begin
			m[i] = (i < shift);
		end
		return m;
	endfunction

	always_comb begin
		mask = tap_mask(BASE + int'(sel));
		tick_out = tick_in && ((q.cnt & mask) == mask);
		d = q;
		if (sys_rst || clear) begin
			d.cnt = '0;
		end else if (tick_in) begin
			d.cnt = q.cnt + 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		q <= d;
	end

endmodule

// >>> testbench/wdt_core_properties.sv
// Concurrent checks on the watchdog core ports
`timescale 1ns/1ps
module wdt_core_chk (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Watched ports
	input wire logic config_watchdog_enable,
	input wire logic osc_startup_timer_active,
	input wire logic crystal_osc_mode,
	input wire logic sleep_active,
	input wire logic watchdog_clear_instr,
	input wire logic watchdog_reset_req,
	input wire logic watchdog_wake,
	input wire logic watchdog_running
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	sequence s_ost_long; osc_startup_timer_active [*3]; endsequence
	sequence s_cfg_on; (config_watchdog_enable && !osc_startup_timer_active && !crystal_osc_mode) [*3]; endsequence
	sequence s_quiet; !watchdog_reset_req && !watchdog_wake; endsequence
	property p_pulse; watchdog_reset_req |=> !watchdog_reset_req; endproperty
	a_pulse: assert property (p_pulse) else $error("reset request too long");
	property p_wake; watchdog_wake |-> $past(sleep_active); endproperty
	a_wake: assert property (p_wake) else $error("wake pulse while awake");
	property p_req; watchdog_reset_req |-> !$past(sleep_active); endproperty
	a_req: assert property (p_req) else $error("reset request while asleep");
	property p_hold; osc_startup_timer_active |=> !watchdog_running; endproperty
	a_hold: assert property (p_hold) else $error("running under start-up timer");
	property p_ost_quiet; s_ost_long |-> s_quiet; endproperty
	a_ost_quiet: assert property (p_ost_quiet) else $error("time-out under start-up timer");
	property p_off; !watchdog_running [*2] |-> s_quiet; endproperty
	a_off: assert property (p_off) else $error("time-out while stopped");
	property p_cfg; s_cfg_on |-> watchdog_running; endproperty
	a_cfg: assert property (p_cfg) else $error("configured watchdog not running");
	property p_clr; watchdog_clear_instr |-> ##2 s_quiet [*8]; endproperty
	a_clr: assert property (p_clr) else $error("time-out right after clear");
endmodule
bind wdt_core wdt_core_chk u_wdt_core_chk (.clock, .sys_rst, .config_watchdog_enable,
	.osc_startup_timer_active, .crystal_osc_mode, .sleep_active, .watchdog_clear_instr,
	.watchdog_reset_req, .watchdog_wake, .watchdog_running);

// >>> testbench/testbench.sv
// Self-checking bench for the watchdog core
`timescale 1ns/1ps
module testbench;
	import wdt_pkg::*;
	logic clock = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, lf = 0, lf_sys = 0, xtal = 0, osc_startup_timer = 0;
	logic ofail = 0, cfg = 0, clr = 0, slp = 0, wake = 0, sct = 0, sc_out, rreq, rwake, run, irq, rd_d = 0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, m, n_rst = 8'h00, n_wake = 8'h00, n_sc = 8'h00;
	logic [7:0] exp_q[$];
	int failures = 0, checks_done = 0, seed = 69667;
	always #2 clock = ~clock;
	wdt_core u_wdt_core (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .low_freq_internal_osc(lf),
		.lf_is_system_clock(lf_sys), .crystal_osc_mode(xtal), .osc_startup_timer_active(osc_startup_timer),
		.osc_fail_detect(ofail), .config_watchdog_enable(cfg), .watchdog_clear_instr(clr),
		.sleep_active(slp), .wake_event(wake), .shared_counter_tick(sct), .shared_counter_presc_tick(sc_out),
		.watchdog_reset_req(rreq), .watchdog_wake(rwake), .watchdog_running(run), .irq(irq));
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("BAD %s exp %0h got %0h", nm, e, g);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge clock);
		reg_wr <= 0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1;
		exp_q.push_back(e);
		@(posedge clock);
		reg_rd <= 0;
	endtask
	task automatic ticks(input int n);
		repeat (n) begin
			repeat (4) @(posedge clock);
			lf <= 1;
			repeat (4) @(posedge clock);
			lf <= 0;
		end
		repeat (12) @(posedge clock);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask
	// Result watcher
	always @(posedge clock) begin
		rd_d <= reg_rd;
		if (rd_d && exp_q.size() > 0) chk("rdata", exp_q.pop_front(), reg_rdata);
		if (!sys_rst && rreq === 1'b1) n_rst <= n_rst + 8'h01;
		if (!sys_rst && rwake === 1'b1) n_wake <= n_wake + 8'h01;
		if (!sys_rst && sc_out === 1'b1) n_sc <= n_sc + 8'h01;
	end
	initial begin
		cyc(100000);
		failures++;
		wrap_up();
	end
	initial begin
		cyc(10);
		sys_rst <= 0;
		rd(WDT_ADR_CTRL, 8'h08);
		rd(WDT_ADR_OPT, 8'h0F);
		rd(WDT_ADR_STATUS, 8'h00);
		rd(4'hF, 8'h00);
		ticks(2);
		rd(WDT_ADR_OSC, 8'h00);
		lf_sys <= 1;
		rd(WDT_ADR_OSC, 8'h01);
		m = 8'($random(seed));
		wr(WDT_ADR_MASK, m);
		rd(WDT_ADR_MASK, {6'h00, m[1:0]});
		wr(WDT_ADR_MASK, 8'h01);
		wr(WDT_ADR_OPT, 8'h07);
		wr(WDT_ADR_CTRL, 8'h01);
		cyc(2);
		chk("running", 8'h01, {7'h00, run});
		ticks(31);
		chk("resets", 8'h00, n_rst);
		ticks(1);
		chk("resets", 8'h01, n_rst);
		chk("irq", 8'h01, {7'h00, irq});
		rd(WDT_ADR_STATUS, 8'h01);
		wr(WDT_ADR_STATUS, 8'h01);
		rd(WDT_ADR_STATUS, 8'h00);
		chk("irq", 8'h00, {7'h00, irq});
		ticks(20);
		clr <= 1;
		cyc(1);
		clr <= 0;
		ticks(20);
		chk("resets", 8'h01, n_rst);
		ticks(12);
		chk("resets", 8'h02, n_rst);
		wr(WDT_ADR_OPT, 8'h09);
		ticks(63);
		chk("resets", 8'h02, n_rst);
		ticks(1);
		chk("resets", 8'h03, n_rst);
		slp <= 1;
		ticks(64);
		slp <= 0;
		chk("wakes", 8'h01, n_wake);
		ticks(40);
		wr(WDT_ADR_CTRL, 8'h00);
		cyc(2);
		chk("running", 8'h00, {7'h00, run});
		wr(WDT_ADR_CTRL, 8'h01);
		ticks(63);
		chk("resets", 8'h03, n_rst);
		wr(WDT_ADR_CTRL, 8'h00);
		cfg <= 1;
		cyc(3);
		chk("running", 8'h01, {7'h00, run});
		osc_startup_timer <= 1;
		cyc(3);
		chk("running", 8'h00, {7'h00, run});
		ticks(70);
		chk("resets", 8'h03, n_rst);
		osc_startup_timer <= 0;
		cyc(3);
		chk("running", 8'h01, {7'h00, run});
		ticks(40);
		ofail <= 1;
		cyc(1);
		ofail <= 0;
		ticks(40);
		chk("resets", 8'h03, n_rst);
		xtal <= 1;
		slp <= 1;
		osc_startup_timer <= 1;
		wake <= 1;
		cyc(1);
		wake <= 0;
		slp <= 0;
		cyc(3);
		chk("running", 8'h00, {7'h00, run});
		osc_startup_timer <= 0;
		cyc(3);
		chk("running", 8'h01, {7'h00, run});
		xtal <= 0;
		cfg <= 0;
		wr(WDT_ADR_OPT, 8'h08);
		repeat (4) begin
			sct <= 1;
			cyc(1);
			sct <= 0;
			cyc(3);
		end
		chk("shared", 8'h04, n_sc);
		wr(WDT_ADR_OPT, 8'h01);
		repeat (4) begin
			sct <= 1;
			cyc(1);
			sct <= 0;
			cyc(3);
		end
		cyc(4);
		chk("shared", 8'h06, n_sc);
		wrap_up();
	end
endmodule
